//--- design/dss_pkg.sv
// Constants, register map and state type for the debug scan and system access block
//
// Summary of operation
// - Data chain has 33 cells: 32 two-way data bus cells plus one two-way break cell.
// - Status bit 4 tells whether debug was entered from the compressed 16-bit state.
// - In debug state any mode change is allowed, even from an unprivileged mode.
// - 33 qualified shifts per instruction or word; core state holds across long pauses.
// - System memory is accessed only under the system clock qualifier; break cell controls it.
// - Break cell low runs at debug speed; set it on the preceding instruction for system speed.
// - On resume the block switches to system qualifier, runs the access, then re-enters debug.
// - Without a bus grant the clock may stall indefinitely; the access stays pending.
// - Transfer type and indicator are readable in the status register.
// - After a system-speed access the first capture loads the break cell high.
// - In debug, store data appears on the data bus where the chain captures it.
// - Chain order from serial in: data bits 0 to 31, then the break cell.
// - Chain shifts one bit per clock with the shift qualifier high, holds otherwise.
// - With the resume instruction current, debug state ends on entering run-test/idle.
// - First capture after entry loads break cell low for breakpoint, high for watchpoint.
package dss_pkg;
  localparam int DSS_DATA_W = 32;
  localparam int DSS_CHAIN_LEN = 33;
  localparam int DSS_BREAK_CELL = 32;
  localparam int DSS_REG_ADDR_W = 4;
  localparam int DSS_ADDR_W = 32;

  localparam logic [DSS_REG_ADDR_W-1:0] DSS_REG_CTRL = 4'h0;
  localparam logic [DSS_REG_ADDR_W-1:0] DSS_REG_STAT = 4'h4;

  localparam int DSS_CTRL_FORCE_IND = 0;
  localparam int DSS_CTRL_HALT_REQ = 1;

  localparam int DSS_STAT_IND = 0;
  localparam int DSS_STAT_BREAK = 1;
  localparam int DSS_STAT_HTRANS_LSB = 2;
  localparam int DSS_STAT_COMPRESSED = 4;
  localparam int DSS_STAT_SYS_PEND = 5;
  localparam int DSS_STAT_CAUSE = 6;

  localparam logic [1:0] DSS_HTRANS_IDLE = 2'h0;
  localparam logic [1:0] DSS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DSS_HTRANS_PARKED = 2'h3;

  localparam logic DSS_CAUSE_BKPT = 1'b0;
  localparam logic DSS_CAUSE_WPT = 1'b1;

  typedef enum logic [2:0] {
    DSS_RUN,
    DSS_DEBUG,
    DSS_SYS_SYNC,
    DSS_SYS_ADDR,
    DSS_SYS_DATA
  } dss_state_e;
endpackage

//--- design/dss_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dss_sync2 (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

//--- design/dss_scan_chain.sv
// Capture, shift and update scan chain with a parallel hold register
`timescale 1ns/1ps
`default_nettype none
module dss_scan_chain #(
  parameter int WIDTH = 33
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic i_update,
  input wire logic i_serial_in,
  input wire logic [WIDTH-1:0] i_par_in,
  output logic o_serial_out,
  output logic [WIDTH-1:0] o_par_out
);
  logic [WIDTH-1:0] shift_ff;
  logic [WIDTH-1:0] hold_ff;
  logic [WIDTH-1:0] shift_src;

  // Cell 0 sits next to serial in, the top cell drives serial out
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_cell
      if (g == 0) begin : g_first
        assign shift_src[g] = i_serial_in;
      end else begin : g_rest
        assign shift_src[g] = shift_ff[g-1];
      end
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          shift_ff[g] <= 1'b0;
        end else if (i_capture) begin
          shift_ff[g] <= i_par_in[g];
        end else if (i_shift) begin
          shift_ff[g] <= shift_src[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_ff <= '0;
    end else if (i_update) begin
      hold_ff <= shift_ff;
    end
  end

  assign o_serial_out = shift_ff[WIDTH-1];
  assign o_par_out = hold_ff;
endmodule
`default_nettype wire

//--- design/dss_debug_access.sv
// Debug-state control: data scan chain, debug/system speed stepping and system bus access
`timescale 1ns/1ps
`default_nettype none
module dss_debug_access
  import dss_pkg::*;
#(
  parameter int DATA_W = DSS_DATA_W,
  parameter int ADDR_W = DSS_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Test port controller, same clock
  input wire logic i_debug_shift_qualifier,
  input wire logic i_debug_serial_in,
  input wire logic i_chain_sel,
  input wire logic i_capture_dr,
  input wire logic i_shift_dr,
  input wire logic i_update_dr,
  input wire logic i_run_idle,
  input wire logic i_resume_sel,
  output logic o_debug_serial_out,
  // Debug entry sources
  input wire logic i_bkpt_hit,
  input wire logic i_wpt_hit,
  input wire logic i_debug_req_pin,
  // Core side
  input wire logic i_core_compressed,
  input wire logic i_core_privileged,
  input wire logic i_core_store_valid,
  input wire logic [DATA_W-1:0] i_core_wdata,
  input wire logic [ADDR_W-1:0] i_core_addr,
  input wire logic i_core_write,
  input wire logic [1:0] i_core_htrans,
  output logic [DATA_W-1:0] o_core_instr,
  output logic o_break_sync_cell,
  output logic o_core_step,
  output logic o_mode_write_ok,
  output logic [DATA_W-1:0] o_core_rdata,
  output logic o_core_rdata_valid,
  output logic o_in_debug_indicator,
  // System bus
  input wire logic i_system_clock_qualifier,
  input wire logic i_hgrant,
  input wire logic i_hready,
  input wire logic [DATA_W-1:0] i_hrdata,
  output logic [1:0] o_htrans,
  output logic [ADDR_W-1:0] o_haddr,
  output logic o_hwrite,
  output logic [DATA_W-1:0] o_hwdata,
  // Register port
  input wire logic [DSS_REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DATA_W-1:0] o_reg_rdata
);
  dss_state_e state_ff;
  dss_state_e nxt_state;

  logic req_sync;
  logic run_idle_ff;
  logic run_idle_rise;
  logic resume_go;
  logic dbg_step;
  logic sys_done;
  logic entry_evt;
  logic cap_en;
  logic shift_en;
  logic upd_en;
  logic [DSS_CHAIN_LEN-1:0] chain_par_in;
  logic [DSS_CHAIN_LEN-1:0] chain_par_out;
  logic break_cap;

  logic arm_sys_ff;
  logic sys_loaded_ff;
  logic first_cap_ff;
  logic cause_ff;
  logic compressed_ff;
  logic force_ind_ff;
  logic halt_req_ff;
  logic [DATA_W-1:0] bus_ff;
  logic [DATA_W-1:0] core_rdata_ff;
  logic core_rdata_valid_ff;
  logic core_step_ff;
  logic mode_ok_ff;
  logic ind_ff;
  logic [1:0] htrans_ff;
  logic [ADDR_W-1:0] haddr_ff;
  logic hwrite_ff;
  logic [DATA_W-1:0] hwdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic sys_write_ff;
  logic [DATA_W-1:0] sys_wdata_ff;

  // The request pin is asynchronous to the bus clock
  dss_sync2 u_req_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_debug_req_pin),
    .o_sync(req_sync)
  );

  assign cap_en = i_capture_dr & i_chain_sel & i_debug_shift_qualifier;
  assign shift_en = i_shift_dr & i_chain_sel & i_debug_shift_qualifier;
  assign upd_en = i_update_dr & i_chain_sel & i_debug_shift_qualifier;

  // First capture after entry reports the cause; later ones read back the applied break value
  assign break_cap = first_cap_ff ? cause_ff : chain_par_out[DSS_BREAK_CELL];
  assign chain_par_in = {break_cap, bus_ff};

  dss_scan_chain #(
    .WIDTH(DSS_CHAIN_LEN)
  ) u_chain (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_capture(cap_en),
    .i_shift(shift_en),
    .i_update(upd_en),
    .i_serial_in(i_debug_serial_in),
    .i_par_in(chain_par_in),
    .o_serial_out(o_debug_serial_out),
    .o_par_out(chain_par_out)
  );

  assign run_idle_rise = i_run_idle & ~run_idle_ff;
  assign resume_go = (state_ff == DSS_DEBUG) & i_resume_sel & run_idle_rise;
  // Debug-speed core clock: one per entry to run-test/idle with the data chain selected and resume not current
  assign dbg_step = (state_ff == DSS_DEBUG) & i_chain_sel & run_idle_rise & ~i_resume_sel;
  assign sys_done = (state_ff == DSS_SYS_DATA) & i_system_clock_qualifier & i_hready;
  assign entry_evt = i_bkpt_hit | i_wpt_hit | req_sync | halt_req_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DSS_RUN: begin
        if (entry_evt) begin
          nxt_state = DSS_DEBUG;
        end
      end
      DSS_DEBUG: begin
        if (resume_go) begin
          nxt_state = sys_loaded_ff ? DSS_SYS_SYNC : DSS_RUN;
        end
      end
      DSS_SYS_SYNC: begin
        // Waits here with no time limit until the arbiter grants the bus
        if (i_system_clock_qualifier && i_hgrant) begin
          nxt_state = DSS_SYS_ADDR;
        end
      end
      DSS_SYS_ADDR: begin
        if (i_system_clock_qualifier && i_hready) begin
          nxt_state = DSS_SYS_DATA;
        end
      end
      DSS_SYS_DATA: begin
        if (sys_done) begin
          nxt_state = DSS_DEBUG;
        end
      end
      default: begin
        nxt_state = DSS_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= DSS_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_idle_ff <= 1'b0;
    end else begin
      run_idle_ff <= i_run_idle;
    end
  end

  // Break cell on a stepped instruction arms system speed for the one after it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arm_sys_ff <= 1'b0;
      sys_loaded_ff <= 1'b0;
    end else if (state_ff != DSS_DEBUG) begin
      arm_sys_ff <= 1'b0;
      sys_loaded_ff <= 1'b0;
    end else if (dbg_step) begin
      arm_sys_ff <= chain_par_out[DSS_BREAK_CELL];
      sys_loaded_ff <= arm_sys_ff;
    end
  end

  // Entry cause and first-capture flag; the set on entry wins over the clear by capture
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_cap_ff <= 1'b0;
      cause_ff <= DSS_CAUSE_BKPT;
      compressed_ff <= 1'b0;
    end else if (state_ff == DSS_RUN && entry_evt) begin
      first_cap_ff <= 1'b1;
      cause_ff <= i_wpt_hit ? DSS_CAUSE_WPT : DSS_CAUSE_BKPT;
      compressed_ff <= i_core_compressed;
    end else if (sys_done) begin
      first_cap_ff <= 1'b1;
      cause_ff <= 1'b1;
    end else if (cap_en) begin
      first_cap_ff <= 1'b0;
    end
  end

  // Data bus value seen by the chain: store data in debug, read data after a system load
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_ff <= '0;
    end else if (sys_done && !sys_write_ff) begin
      bus_ff <= i_hrdata;
    end else if (state_ff == DSS_DEBUG && i_core_store_valid) begin
      bus_ff <= i_core_wdata;
    end
  end

  // Core clocking: free under the system qualifier when running, stepped in debug
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_step_ff <= 1'b0;
    end else begin
      core_step_ff <= ((state_ff == DSS_RUN) & i_system_clock_qualifier) | dbg_step | sys_done;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ok_ff <= 1'b0;
    end else begin
      mode_ok_ff <= i_core_privileged | (nxt_state != DSS_RUN);
    end
  end

  // Indicator drops during the system access and in run state; software forcing holds it up only during the access
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ind_ff <= 1'b0;
    end else begin
      ind_ff <= (nxt_state == DSS_DEBUG) | ((nxt_state != DSS_RUN) & force_ind_ff);
    end
  end

  // Parked at all-ones in debug so completion polls see both bits high
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      htrans_ff <= DSS_HTRANS_IDLE;
    end else begin
      case (nxt_state)
        DSS_RUN: htrans_ff <= i_core_htrans;
        DSS_DEBUG: htrans_ff <= DSS_HTRANS_PARKED;
        DSS_SYS_SYNC: htrans_ff <= DSS_HTRANS_IDLE;
        DSS_SYS_ADDR: htrans_ff <= DSS_HTRANS_NONSEQ;
        DSS_SYS_DATA: htrans_ff <= DSS_HTRANS_IDLE;
        default: htrans_ff <= DSS_HTRANS_IDLE;
      endcase
    end
  end

  // Only single transfers: a load or store multiple runs as repeated system accesses
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      haddr_ff <= '0;
      hwrite_ff <= 1'b0;
      sys_write_ff <= 1'b0;
      sys_wdata_ff <= '0;
    end else if (resume_go && sys_loaded_ff) begin
      haddr_ff <= i_core_addr;
      hwrite_ff <= i_core_write;
      sys_write_ff <= i_core_write;
      sys_wdata_ff <= i_core_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hwdata_ff <= '0;
    end else if (state_ff == DSS_SYS_ADDR && nxt_state == DSS_SYS_DATA) begin
      hwdata_ff <= sys_wdata_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_rdata_ff <= '0;
      core_rdata_valid_ff <= 1'b0;
    end else begin
      core_rdata_valid_ff <= sys_done & ~sys_write_ff;
      if (sys_done && !sys_write_ff) begin
        core_rdata_ff <= i_hrdata;
      end
    end
  end

  // Control register; a halt request set by software is cleared on debug entry, set wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      force_ind_ff <= 1'b0;
      halt_req_ff <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == DSS_REG_CTRL) begin
      force_ind_ff <= i_reg_wdata[DSS_CTRL_FORCE_IND];
      halt_req_ff <= i_reg_wdata[DSS_CTRL_HALT_REQ];
    end else if (state_ff == DSS_RUN && entry_evt) begin
      halt_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= '0;
    end else if (i_reg_rd) begin
      rdata_ff <= '0;
      case (i_reg_addr)
        DSS_REG_CTRL: begin
          rdata_ff[DSS_CTRL_FORCE_IND] <= force_ind_ff;
          rdata_ff[DSS_CTRL_HALT_REQ] <= halt_req_ff;
        end
        DSS_REG_STAT: begin
          rdata_ff[DSS_STAT_IND] <= ind_ff;
          rdata_ff[DSS_STAT_BREAK] <= chain_par_out[DSS_BREAK_CELL];
          rdata_ff[DSS_STAT_HTRANS_LSB+1:DSS_STAT_HTRANS_LSB] <= htrans_ff;
          rdata_ff[DSS_STAT_COMPRESSED] <= compressed_ff;
          rdata_ff[DSS_STAT_SYS_PEND] <= sys_loaded_ff;
          rdata_ff[DSS_STAT_CAUSE] <= cause_ff;
        end
        default: begin
          rdata_ff <= '0;
        end
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign o_core_instr = chain_par_out[DATA_W-1:0];
  assign o_break_sync_cell = chain_par_out[DSS_BREAK_CELL];
  assign o_core_step = core_step_ff;
  assign o_mode_write_ok = mode_ok_ff;
  assign o_core_rdata = core_rdata_ff;
  assign o_core_rdata_valid = core_rdata_valid_ff;
  assign o_in_debug_indicator = ind_ff;
  assign o_htrans = htrans_ff;
  assign o_haddr = haddr_ff;
  assign o_hwrite = hwrite_ff;
  assign o_hwdata = hwdata_ff;
  assign o_reg_rdata = rdata_ff;
endmodule
`default_nettype wire

//--- verif/dss_props.sv
// Port assertions for the debug access block
`timescale 1ns/1ps
`default_nettype none
module dss_props
  import dss_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_debug_shift_qualifier,
  input wire logic i_run_idle,
  input wire logic i_resume_sel,
  input wire logic [DSS_DATA_W-1:0] i_hrdata,
  input wire logic [DSS_REG_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic o_debug_serial_out,
  input wire logic [DSS_DATA_W-1:0] o_core_instr,
  input wire logic o_break_sync_cell,
  input wire logic o_core_step,
  input wire logic o_mode_write_ok,
  input wire logic [DSS_DATA_W-1:0] o_core_rdata,
  input wire logic o_core_rdata_valid,
  input wire logic o_in_debug_indicator,
  input wire logic [1:0] o_htrans,
  input wire logic [DSS_DATA_W-1:0] o_reg_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_chain_hold: assert property (
    !i_debug_shift_qualifier |=> $stable({o_debug_serial_out, o_break_sync_cell, o_core_instr}))
    else $error("chain moved without qualifier");
  a_done_parked: assert property (
    o_core_rdata_valid |-> o_in_debug_indicator && o_htrans == DSS_HTRANS_PARKED && o_core_step)
    else $error("access end not parked");
  a_load_data: assert property (
    o_core_rdata_valid |-> o_core_rdata == $past(i_hrdata))
    else $error("load data wrong");
  a_valid_pulse: assert property (
    o_core_rdata_valid |=> !o_core_rdata_valid)
    else $error("load valid too long");
  a_read_idle: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == '0)
    else $error("read data without strobe");
  a_unmapped_read: assert property (
    i_reg_rd && i_reg_addr != DSS_REG_CTRL && i_reg_addr != DSS_REG_STAT |=> o_reg_rdata == '0)
    else $error("unmapped read not zero");
  a_status_mirror: assert property (
    i_reg_rd && i_reg_addr == DSS_REG_STAT |=> o_reg_rdata[DSS_STAT_IND] == $past(o_in_debug_indicator)
      && o_reg_rdata[DSS_STAT_HTRANS_LSB +: 2] == $past(o_htrans))
    else $error("status does not mirror pins");
  a_mode_debug: assert property (
    o_in_debug_indicator [*2] |-> o_mode_write_ok)
    else $error("mode write blocked in debug");
  a_step_pulse: assert property (
    $rose(i_run_idle) && !i_resume_sel && o_in_debug_indicator |=> o_core_step ##1 !o_core_step)
    else $error("debug step not one pulse");
  c_load: cover property (o_core_rdata_valid);
  c_resume: cover property ($rose(i_run_idle) && i_resume_sel);
  c_stat: cover property (i_reg_rd && i_reg_addr == DSS_REG_STAT && o_in_debug_indicator);
endmodule
bind dss_debug_access dss_props u_props (.i_clk, .i_arst_n, .i_debug_shift_qualifier, .i_run_idle,
  .i_resume_sel, .i_hrdata, .i_reg_addr, .i_reg_rd, .o_debug_serial_out, .o_core_instr,
  .o_break_sync_cell, .o_core_step, .o_mode_write_ok, .o_core_rdata, .o_core_rdata_valid,
  .o_in_debug_indicator, .o_htrans, .o_reg_rdata);
`default_nettype wire

//--- verif/dss_dbg_model.sv
// Debugger model driving the test-port side of the data scan chain
`timescale 1ns/1ps
`default_nettype none
module dss_dbg_model (
  input wire logic i_clk,
  input wire logic i_serial_out,
  output var logic o_qual,
  output var logic o_sin,
  output var logic o_sel,
  output var logic o_cap,
  output var logic o_shift,
  output var logic o_upd,
  output var logic o_idle,
  output var logic o_resume
);
  initial begin
    {o_qual, o_sin, o_sel, o_cap, o_shift, o_upd, o_idle, o_resume} = 8'h00;
  end
  // One qualified cycle then a dead one, so the chain must hold between slow test clocks
  task automatic act(input logic c, input logic s, input logic u, input logic d);
    @(posedge i_clk);
    o_sel <= 1'b1;
    o_qual <= 1'b1;
    o_cap <= c;
    o_shift <= s;
    o_upd <= u;
    o_sin <= d;
    @(posedge i_clk);
    o_qual <= 1'b0;
    o_sin <= ~d; // Released line must not keep the last bit
    @(negedge i_clk);
  endtask
  task automatic scan(input logic [32:0] v, output logic [32:0] got);
    act(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 32; i >= 0; i--) begin
      got[i] = i_serial_out;
      act(1'b0, 1'b1, 1'b0, v[i]);
    end
    act(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge i_clk);
    o_upd <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic step(input logic res);
    @(posedge i_clk);
    o_idle <= 1'b1;
    o_resume <= res;
    @(posedge i_clk);
    o_idle <= 1'b0;
    o_resume <= 1'b0;
    @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- verif/dss_debug_access_tb.sv
// Self-checking testbench for the debug access block
`timescale 1ns/1ps
`default_nettype none
module dss_debug_access_tb;
  import dss_pkg::*;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_bkpt_hit = 1'b0, i_wpt_hit = 1'b0, i_debug_req_pin = 1'b0;
  logic i_core_compressed = 1'b0, i_core_privileged = 1'b0, i_core_store_valid = 1'b0, i_core_write = 1'b0;
  logic i_system_clock_qualifier = 1'b1, i_hgrant = 1'b0, i_hready = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [1:0] i_core_htrans = 2'h0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [31:0] i_core_wdata = 32'h0, i_core_addr = 32'h0, i_hrdata = 32'h0, i_reg_wdata = 32'h0;
  logic i_debug_shift_qualifier, i_debug_serial_in, i_chain_sel, i_capture_dr, i_shift_dr, i_update_dr;
  logic i_run_idle, i_resume_sel, o_debug_serial_out, o_break_sync_cell, o_core_step, o_mode_write_ok;
  logic o_core_rdata_valid, o_in_debug_indicator, o_hwrite;
  logic [1:0] o_htrans;
  logic [31:0] o_core_instr, o_core_rdata, o_haddr, o_hwdata, o_reg_rdata;
  int error_cnt = 0, total_checks = 0;
  always #12.5 i_clk = ~i_clk;
  dss_debug_access DUT (.i_clk, .i_arst_n, .i_debug_shift_qualifier, .i_debug_serial_in, .i_chain_sel,
    .i_capture_dr, .i_shift_dr, .i_update_dr, .i_run_idle, .i_resume_sel, .o_debug_serial_out,
    .i_bkpt_hit, .i_wpt_hit, .i_debug_req_pin, .i_core_compressed, .i_core_privileged,
    .i_core_store_valid, .i_core_wdata, .i_core_addr, .i_core_write, .i_core_htrans, .o_core_instr,
    .o_break_sync_cell, .o_core_step, .o_mode_write_ok, .o_core_rdata, .o_core_rdata_valid,
    .o_in_debug_indicator, .i_system_clock_qualifier, .i_hgrant, .i_hready, .i_hrdata, .o_htrans,
    .o_haddr, .o_hwrite, .o_hwdata, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  dss_dbg_model u_dbg (.i_clk, .i_serial_out(o_debug_serial_out), .o_qual(i_debug_shift_qualifier),
    .o_sin(i_debug_serial_in), .o_sel(i_chain_sel), .o_cap(i_capture_dr), .o_shift(i_shift_dr),
    .o_upd(i_update_dr), .o_idle(i_run_idle), .o_resume(i_resume_sel));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    d = o_reg_rdata;
  endtask
  task automatic t_enter_store();
    logic [31:0] d;
    logic [32:0] got;
    rd(4'h8, d);
    chk(d, 32'h0);
    wr(DSS_REG_CTRL, 32'h1 << DSS_CTRL_HALT_REQ);
    repeat (2) @(posedge i_clk);
    rd(DSS_REG_STAT, d);
    chk({d[DSS_STAT_CAUSE], d[DSS_STAT_COMPRESSED], d[DSS_STAT_IND]}, 3'h1);
    chk(o_mode_write_ok, 1'b1);
    @(posedge i_clk);
    i_core_wdata <= 32'hA5C30F96;
    i_core_store_valid <= 1'b1;
    @(posedge i_clk);
    i_core_store_valid <= 1'b0;
    u_dbg.scan({1'b1, 32'hE5901000}, got);
    chk(got, {1'b0, 32'hA5C30F96});
    chk({o_break_sync_cell, o_core_instr}, {1'b1, 32'hE5901000});
    $display("test enter_store done");
  endtask
  task automatic t_sys_access();
    logic [31:0] d;
    logic [32:0] got;
    int n;
    u_dbg.step(1'b0);
    u_dbg.scan({1'b0, 32'hE5912004}, got);
    u_dbg.step(1'b0);
    @(posedge i_clk);
    i_system_clock_qualifier <= 1'b0;
    i_hgrant <= 1'b1;
    i_core_addr <= 32'h20004000;
    i_core_htrans <= 2'h2;
    i_hrdata <= 32'hC0FFEE42;
    u_dbg.step(1'b1);
    for (n = 0; n < 4; n++) begin
      chk({o_in_debug_indicator, o_htrans}, {1'b0, DSS_HTRANS_IDLE});
      @(negedge i_clk);
    end
    @(posedge i_clk);
    i_system_clock_qualifier <= 1'b1;
    i_hgrant <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(negedge i_clk);
      chk(o_htrans, DSS_HTRANS_IDLE);
    end
    // A wait state must hold the address phase
    @(posedge i_clk);
    i_hgrant <= 1'b1;
    i_hready <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk({o_in_debug_indicator, o_htrans, o_hwrite, o_haddr},
      {1'b0, DSS_HTRANS_NONSEQ, 1'b0, 32'h20004000});
    @(posedge i_clk);
    i_hready <= 1'b1;
    for (n = 0; n < 20 && o_core_rdata_valid !== 1'b1; n++) begin
      @(negedge i_clk);
    end
    chk({o_core_rdata_valid, o_in_debug_indicator, o_htrans, o_core_rdata},
      {2'h3, DSS_HTRANS_PARKED, 32'hC0FFEE42});
    rd(DSS_REG_STAT, d);
    chk({d[DSS_STAT_HTRANS_LSB +: 2], d[DSS_STAT_IND]}, 3'h7);
    u_dbg.scan({1'b0, 32'hE1A00000}, got);
    chk(got, {1'b1, 32'hC0FFEE42});
    $display("test sys_access done");
  endtask
  task automatic t_exit_watch();
    logic [31:0] d;
    logic [32:0] got;
    u_dbg.step(1'b0);
    u_dbg.scan({1'b0, 32'hE1A00000}, got);
    u_dbg.step(1'b0);
    u_dbg.step(1'b1);
    chk(o_in_debug_indicator, 1'b0);
    @(negedge i_clk);
    chk({o_mode_write_ok, o_htrans}, 3'h2);
    @(posedge i_clk);
    i_core_privileged <= 1'b1;
    i_core_compressed <= 1'b1;
    i_wpt_hit <= 1'b1;
    @(posedge i_clk);
    i_wpt_hit <= 1'b0;
    @(negedge i_clk);
    chk({o_in_debug_indicator, o_mode_write_ok}, 2'h3);
    rd(DSS_REG_STAT, d);
    chk({d[DSS_STAT_CAUSE], d[DSS_STAT_COMPRESSED]}, 2'h3);
    u_dbg.scan({1'b0, 32'h46C046C0}, got);
    chk(got[32], 1'b1);
    $display("test exit_watch done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_enter_store();
    t_sys_access();
    t_exit_watch();
    tally_and_finish();
  end
  // Whole run needs about 400 cycles
  initial begin
    repeat (6000) @(posedge i_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
